// File: rtl/cantxr_pkg.sv
// shared constants for the transmit buffers and receive filter block
package cantxr_pkg;
  localparam int          N_TX        = 3;
  localparam int          MSG_BYTES   = 13;
  localparam int          FRAME_W     = MSG_BYTES * 8;
  localparam int          HIT_W       = 3;
  localparam int          RX_DEPTH    = 4;
  // byte offsets inside one buffer window
  localparam logic [3:0]  OFS_DATA0   = 4'h4;
  localparam logic [3:0]  OFS_DLC     = 4'hC;
  localparam logic [3:0]  OFS_LOCAL_PRIORITY    = 4'hD;
  localparam logic [3:0]  OFS_TS_HI   = 4'hE;
  localparam logic [3:0]  OFS_TS_LO   = 4'hF;
  localparam int          IDE_BIT     = 11;
  localparam logic [3:0]  DLC_MAX     = 4'h8;
  // reset values
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [7:0]  MASK_RST    = 8'hFF;
  // acceptance filter modes
  localparam logic [1:0]  FMODE_TWO   = 2'h0;
  localparam logic [1:0]  FMODE_FOUR  = 2'h1;
  localparam logic [1:0]  FMODE_EIGHT = 2'h2;
  localparam logic [1:0]  FMODE_CLOSE = 2'h3;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} cantxr_txst_t;
endpackage

// File: rtl/cantxr_filter.sv
// identifier acceptance filter, four modes, lowest hit wins
`timescale 1ns/1ps
`default_nettype none
module cantxr_filter
  import cantxr_pkg::*;
(
  // identifier bytes and filter setup
  input  wire logic [31:0]      ident,
  input  wire logic [63:0]      acc,
  input  wire logic [63:0]      msk,
  input  wire logic [1:0]       mode,
  // result
  output logic                  hit,
  output logic [HIT_W-1:0]      hit_idx
);
  logic [7:0] eq;
  logic [7:0] fh;

  // per acceptance byte compare, mask bit set means don't care
  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_byte
      logic [1:0] isel;
      assign isel = (mode == FMODE_TWO) ? 2'(k % 4) : (mode == FMODE_FOUR) ? 2'(k % 2) : 2'h0;
      assign eq[k] = ((acc[8*k+:8] ^ ident[8*isel+:8]) & ~msk[8*k+:8]) == 8'h00; // see RULE13 see RULE14
    end
  endgenerate

  // group byte matches into filters for the selected mode
  always_comb
  begin
    fh = 8'h00;
    case (mode)
      FMODE_TWO:   fh = {6'h00, &eq[7:4], &eq[3:0]}; // see RULE18 see RULE19
      FMODE_FOUR:  fh = {4'h0, &eq[7:6], &eq[5:4], &eq[3:2], &eq[1:0]};
      FMODE_EIGHT: fh = eq;
      default:     fh = 8'h00; // closed: nothing accepted
    endcase
  end

  // lowest numbered matching filter reports the hit
  always_comb
  begin
    hit = |fh;
    hit_idx = '0;
    for (int i = 7; i >= 0; i--)
      if (fh[i])
        hit_idx = HIT_W'(i); // see RULE16 see RULE17
  end
endmodule
`default_nettype wire

// File: rtl/cantxr_txsel.sv
// picks the ready transmit buffer with the smallest priority value
`timescale 1ns/1ps
`default_nettype none
module cantxr_txsel
  import cantxr_pkg::*;
(
  // ready buffers and their local priorities
  input  wire logic [N_TX-1:0]   ready,
  input  wire logic [8*N_TX-1:0] local_priority,
  // choice
  output logic                   any,
  output logic [1:0]             pick
);
  logic [7:0] best;

  // ties go to the lower buffer number because later equal values lose
  always_comb
  begin
    any = 1'b0;
    pick = 2'h0;
    best = 8'hFF;
    for (int i = 0; i < N_TX; i++)
      if (ready[i] && (!any || local_priority[8*i+:8] < best))
      begin
        any = 1'b1;
        pick = 2'(i); // see RULE21 see RULE24
        best = local_priority[8*i+:8];
      end
  end
endmodule
`default_nettype wire

// File: rtl/cantxr_top.sv
// transmit buffers, background receive buffer, receive fifo and filter
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - three transmit buffers, each a 13-byte message plus 8-bit local priority
// RULE2 - each buffer has two time stamp bytes filled when stamping is on
// RULE3 - software picks a buffer whose empty flag is set
// RULE4 - select write maps a free buffer into the single window
// RULE5 - software loads the buffer then clears its empty flag to send
// RULE6 - every incoming frame lands in the background receive buffer
// RULE7 - invalid frames are overwritten by the next and never enter the fifo
// RULE8 - own frames while sending are captured but not stored, flagged or acked
// RULE9 - in loopback own frames are handled like any other frame
// RULE10 - on lost arbitration the device becomes receiver of the winning frame
// RULE11 - accepted frame with full fifo is dropped and overrun flagged if enabled
// RULE12 - full fifo still transmits, drops input, accepts again once freed
// RULE13 - received identifiers compared against acceptance registers
// RULE14 - mask bits set exclude identifier bits from comparison
// RULE15 - accepted frame sets receive full flag and three-bit hit index
// RULE16 - several matching filters report the lowest numbered one
// RULE17 - filter has four modes differing in filter count and width
// RULE18 - two-filter mode covers full extended or standard id with control bits
// RULE19 - acceptance and mask bytes 0-3 form filter 0, bytes 4-7 filter 1
// RULE20 - software should prefer four or eight filters for standard ids
// RULE21 - with several ready buffers the highest priority goes first
// RULE22 - identifier extension bit 0 means standard, 1 means extended
// RULE23 - payload bytes used follow the buffer's length code
// RULE24 - smallest local priority value wins selection
module cantxr_top
  import cantxr_pkg::*;
#(
  parameter int DEPTH = RX_DEPTH
)
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // software side: buffer selection and window
  input  wire logic                 sel_wr,
  input  wire logic [N_TX-1:0]      sel_data,
  input  wire logic                 win_wr,
  input  wire logic [3:0]           win_addr,
  input  wire logic [7:0]           win_wdata,
  input  wire logic [N_TX-1:0]      tx_release,
  output logic [N_TX-1:0]           tx_buffer_empty_flag_ff,
  output logic [N_TX-1:0]           tx_buffer_select_ff,
  output logic [7:0]                win_rdata_ff,
  // software side: configuration
  input  wire logic                 loopback,
  input  wire logic                 ts_enable,
  input  wire logic                 ovr_ie,
  input  wire logic [1:0]           filter_mode,
  input  wire logic                 accept_wr,
  input  wire logic [3:0]           accept_addr,
  input  wire logic [7:0]           accept_data,
  // software side: receive fifo
  input  wire logic [3:0]           rx_rd_idx,
  input  wire logic                 rx_release,
  output logic [7:0]                rx_rdata_ff,
  output logic                      rx_full_flag_ff,
  output logic [HIT_W-1:0]          filter_hit_index_ff,
  output logic                      overrun_ff,
  // bit engine side: transmit
  output logic                      tx_req_ff,
  output logic [1:0]                tx_pick_ff,
  output logic                      tx_extended_ff,
  output logic [FRAME_W-1:0]        tx_frame_ff,
  output logic                      ack_allow_ff,
  input  wire logic                 tx_done,
  input  wire logic                 arb_lost,
  input  wire logic [15:0]          ts_value,
  // bit engine side: receive
  input  wire logic                 rx_byte_wr,
  input  wire logic [3:0]           rx_byte_idx,
  input  wire logic [7:0]           rx_byte,
  input  wire logic                 frame_end,
  input  wire logic                 frame_ok
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // zero the payload bytes that lie beyond the length code
  function automatic logic [FRAME_W-1:0] mask_payload(input logic [FRAME_W-1:0] f);
    logic [3:0] dlc;
    dlc = (f[8*OFS_DLC+:4] > DLC_MAX) ? DLC_MAX : f[8*OFS_DLC+:4];
    for (int i = 0; i < 8; i++)
      if (4'(i) >= dlc)
        f[8*(OFS_DATA0+i)+:8] = 8'h00;
    return f;
  endfunction

  logic [7:0]           tx_mem [N_TX][16];
  logic [7:0]           bg_mem [MSG_BYTES];
  logic [FRAME_W+HIT_W-1:0] fifo_mem [DEPTH];
  logic [63:0]          acc_ff;
  logic [63:0]          msk_ff;
  logic [1:0]           sel_idx_ff;
  logic                 sel_ok_ff;
  cantxr_txst_t         st_ff;
  logic [PW-1:0]        wr_ptr_ff;
  logic [PW-1:0]        rd_ptr_ff;
  logic [CW-1:0]        cnt_ff;
  logic [N_TX-1:0]      ready;
  logic [8*N_TX-1:0]    local_priority;
  logic                 any_rdy;
  logic [1:0]           best;
  logic [FRAME_W-1:0]   bg_flat;
  logic [FRAME_W-1:0]   best_flat;
  logic                 hit;
  logic [HIT_W-1:0]     hit_idx;
  logic                 own;
  logic                 lost_ff;
  logic                 want;
  logic                 push;
  logic                 pop;
  logic [1:0]           nxt_sel;
  logic                 nxt_ok;

  // flatten buffers for the selector, filter and fifo
  always_comb
  begin
    ready = ~tx_buffer_empty_flag_ff;
    best_flat = '0;
    bg_flat = '0;
    for (int i = 0; i < N_TX; i++)
      local_priority[8*i+:8] = tx_mem[i][OFS_LOCAL_PRIORITY]; // see RULE1
    for (int j = 0; j < MSG_BYTES; j++)
    begin
      best_flat[8*j+:8] = tx_mem[best][j];
      bg_flat[8*j+:8] = bg_mem[j];
    end
  end

  cantxr_txsel u_sel (
    .ready (ready),
    .local_priority  (local_priority),
    .any   (any_rdy),
    .pick  (best)
  );

  cantxr_filter u_filt (
    .ident   (bg_flat[31:0]),
    .acc     (acc_ff),
    .msk     (msk_ff),
    .mode    (filter_mode),
    .hit     (hit),
    .hit_idx (hit_idx)
  );

  // lowest free buffer among those software asked for gets mapped
  always_comb
  begin
    nxt_sel = sel_idx_ff;
    nxt_ok = sel_ok_ff;
    if (sel_wr)
    begin
      nxt_ok = 1'b0;
      for (int i = N_TX - 1; i >= 0; i--)
        if (sel_data[i] && tx_buffer_empty_flag_ff[i])
        begin
          nxt_sel = 2'(i); // see RULE4 see RULE3
          nxt_ok = 1'b1;
        end
    end
  end

  // selection register and its read back
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_idx_ff <= 2'h0;
      sel_ok_ff <= 1'b0;
      tx_buffer_select_ff <= '0;
    end
    else
    begin
      sel_idx_ff <= nxt_sel;
      sel_ok_ff <= nxt_ok;
      tx_buffer_select_ff <= nxt_ok ? N_TX'(1 << nxt_sel) : '0;
    end
  end

  // buffer memory: window writes and time stamp capture at end of send
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < N_TX; i++)
        for (int j = 0; j < 16; j++)
          tx_mem[i][j] <= BYTE_RST;
    end
    else
    begin
      if (win_wr && sel_ok_ff)
        tx_mem[sel_idx_ff][win_addr] <= win_wdata; // see RULE4
      if (tx_done && st_ff == TX_SEND && ts_enable)
      begin
        tx_mem[tx_pick_ff][OFS_TS_HI] <= ts_value[15:8]; // see RULE2
        tx_mem[tx_pick_ff][OFS_TS_LO] <= ts_value[7:0];
      end
    end
  end

  // window read returns the mapped buffer, nothing when unmapped
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      win_rdata_ff <= 8'h00;
    else
      win_rdata_ff <= sel_ok_ff ? tx_mem[sel_idx_ff][win_addr] : 8'h00;
  end

  // empty flags: completion sets, release clears, set wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tx_buffer_empty_flag_ff <= '1;
    else
    begin
      for (int i = 0; i < N_TX; i++)
        if (tx_done && st_ff == TX_SEND && tx_pick_ff == 2'(i))
          tx_buffer_empty_flag_ff[i] <= 1'b1;
        else if (tx_release[i])
          tx_buffer_empty_flag_ff[i] <= 1'b0; // see RULE5
    end
  end

  // transmit sequencer; a lost arbitration leaves the buffer queued for retry
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= TX_IDLE;
      tx_req_ff <= 1'b0;
      tx_pick_ff <= 2'h0;
      tx_extended_ff <= 1'b0;
      tx_frame_ff <= '0;
    end
    else
    begin
      case (st_ff)
        TX_IDLE:
          if (any_rdy)
          begin
            st_ff <= TX_SEND;
            tx_req_ff <= 1'b1;
            tx_pick_ff <= best; // see RULE21
            tx_extended_ff <= best_flat[IDE_BIT]; // see RULE22
            tx_frame_ff <= mask_payload(best_flat); // see RULE23
          end
        TX_SEND:
          if (tx_done || arb_lost)
          begin
            st_ff <= TX_IDLE; // see RULE10
            tx_req_ff <= 1'b0;
          end
        default:
        begin
          st_ff <= TX_IDLE;
          tx_req_ff <= 1'b0;
        end
      endcase
    end
  end

  // acceptance and mask bytes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_ff <= '0;
      msk_ff <= {8{MASK_RST}};
    end
    else if (accept_wr)
    begin
      if (accept_addr[3])
        msk_ff[8*accept_addr[2:0]+:8] <= accept_data;
      else
        acc_ff[8*accept_addr[2:0]+:8] <= accept_data;
    end
  end

  // background buffer simply takes every byte, so a bad frame gets overwritten
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int j = 0; j < MSG_BYTES; j++)
        bg_mem[j] <= BYTE_RST;
    end
    else if (rx_byte_wr && rx_byte_idx < 4'(MSG_BYTES))
      bg_mem[rx_byte_idx] <= rx_byte; // see RULE6 see RULE7
  end

  // store decision; own frames count only in loopback
  always_comb
  begin
    own = (st_ff == TX_SEND) && !loopback && !lost_ff; // see RULE8 see RULE9 see RULE10
    want = frame_end && frame_ok && !own && hit; // see RULE13
    push = want && (cnt_ff != FULL_CNT); // see RULE11 see RULE12
    pop = rx_release && (cnt_ff != '0);
  end

  // receive fifo pointers and storage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      for (int d = 0; d < DEPTH; d++)
        fifo_mem[d] <= '0;
    end
    else
    begin
      if (push)
      begin
        fifo_mem[wr_ptr_ff] <= {hit_idx, mask_payload(bg_flat)}; // see RULE15
        wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end

  // software view of the fifo head, one cycle behind the pointers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_full_flag_ff <= 1'b0;
      filter_hit_index_ff <= '0;
      rx_rdata_ff <= 8'h00;
    end
    else
    begin
      rx_full_flag_ff <= cnt_ff != '0; // see RULE15
      filter_hit_index_ff <= fifo_mem[rd_ptr_ff][FRAME_W+:HIT_W];
      rx_rdata_ff <= (rx_rd_idx < 4'(MSG_BYTES)) ? fifo_mem[rd_ptr_ff][8*rx_rd_idx+:8] : 8'h00;
    end
  end

  // overrun pulse, acknowledge permission and lost arbitration mark
  // the retry may already be queued, so the winner's frame stays foreign until its end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      overrun_ff <= 1'b0;
      ack_allow_ff <= 1'b1;
      lost_ff <= 1'b0;
    end
    else
    begin
      overrun_ff <= want && (cnt_ff == FULL_CNT) && ovr_ie; // see RULE11
      ack_allow_ff <= !own; // see RULE8
      if (st_ff == TX_SEND && arb_lost && !tx_done)
        lost_ff <= 1'b1; // see RULE10
      else if (frame_end)
        lost_ff <= 1'b0;
    end
  end

  a_sel_window: assert property (@(posedge core_clk) disable iff (rst) // see RULE4
    sel_wr && |(sel_data & tx_buffer_empty_flag_ff) ##1 1'b1 |=>
      (tx_buffer_select_ff & $past(sel_data, 2)) != '0 && $onehot(tx_buffer_select_ff))
    else $error("selected buffer not mapped to window");

  a_own_drop: assert property (@(posedge core_clk) disable iff (rst) // see RULE8
    frame_end && st_ff == TX_SEND && !loopback && !lost_ff |=> !ack_allow_ff && $stable(wr_ptr_ff))
    else $error("own frame stored or acknowledged");

  a_lost_store: assert property (@(posedge core_clk) disable iff (rst) // see RULE10
    frame_end && frame_ok && lost_ff && hit && cnt_ff < FULL_CNT && !rx_release |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("frame after lost arbitration not stored");

  a_loop_store: assert property (@(posedge core_clk) disable iff (rst) // see RULE9
    frame_end && frame_ok && loopback && hit && cnt_ff < FULL_CNT && !rx_release |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("loopback frame not stored");

  a_bad_frame: assert property (@(posedge core_clk) disable iff (rst) // see RULE7
    frame_end && !frame_ok |=> $stable(wr_ptr_ff) ##1 !overrun_ff)
    else $error("invalid frame reached fifo");

  a_ovr_flag: assert property (@(posedge core_clk) disable iff (rst) // see RULE11
    want && cnt_ff == FULL_CNT |=> overrun_ff == $past(ovr_ie) && $stable(wr_ptr_ff))
    else $error("overrun not handled");

  a_full_hold: assert property (@(posedge core_clk) disable iff (rst) // see RULE12
    cnt_ff == FULL_CNT && !rx_release |=> cnt_ff == FULL_CNT ##1 rx_full_flag_ff)
    else $error("full fifo changed without release");

  a_local_priority_pick: assert property (@(posedge core_clk) disable iff (rst) // see RULE24
    st_ff == TX_IDLE && any_rdy |=> tx_req_ff && tx_pick_ff == $past(best)
      && !tx_buffer_empty_flag_ff[tx_pick_ff])
    else $error("wrong buffer chosen");

  a_arb_recv: assert property (@(posedge core_clk) disable iff (rst) // see RULE10
    st_ff == TX_SEND && arb_lost && !tx_done |=> !tx_req_ff ##1 ack_allow_ff || loopback)
    else $error("lost arbitration did not yield receiver");

  a_stamp: assert property (@(posedge core_clk) disable iff (rst) // see RULE2
    st_ff == TX_SEND && tx_done && ts_enable |=>
      {tx_mem[$past(tx_pick_ff)][OFS_TS_HI], tx_mem[$past(tx_pick_ff)][OFS_TS_LO]} == $past(ts_value))
    else $error("time stamp not captured");
endmodule
`default_nettype wire

// File: testbench/cantxr_eng_model.sv
// bit engine and bus model facing the transmit and receive ports
`timescale 1ns/1ps
`default_nettype none
module cantxr_eng_model
  import cantxr_pkg::*;
(
  // clock and request
  input  wire logic       core_clk,
  input  wire logic       tx_req_ff,
  // transmit answers
  output var logic        tx_done,
  output var logic        arb_lost,
  output var logic [15:0] ts_value,
  // receive side
  output var logic        rx_byte_wr,
  output var logic [3:0]  rx_byte_idx,
  output var logic [7:0]  rx_byte,
  output var logic        frame_end,
  output var logic        frame_ok
);
  int cnt;
  int busy = 3; // send length, the bench makes it prompt or slow
  bit lose;     // bench asks for one lost arbitration
  initial
  begin
    {tx_done, arb_lost, rx_byte_wr, frame_end, frame_ok} = '0;
    {ts_value, rx_byte_idx, rx_byte} = '0;
    cnt = 0;
  end
  // answer a request after busy cycles with a one-cycle pulse
  always @(posedge core_clk)
  begin
    #1;
    if (tx_done || arb_lost)
    begin
      {tx_done, arb_lost} = 2'h0;
      cnt = 0;
    end
    else if (tx_req_ff)
    begin
      cnt = cnt + 1;
      if (cnt >= busy)
      begin
        arb_lost = lose;
        tx_done = !lose;
        lose = 0;
      end
    end
    else
      cnt = 0;
  end
  // one frame, bytes 0 to 12, then the end strobe; idle lines flip so stale data never looks valid
  task automatic send_rx(input logic [FRAME_W-1:0] f, input logic ok);
    for (int k = 0; k < MSG_BYTES; k++)
    begin
      @(posedge core_clk);
      #1;
      rx_byte_wr = 1'h1;
      rx_byte_idx = k[3:0];
      rx_byte = f[8*k +: 8];
    end
    @(posedge core_clk);
    #1;
    rx_byte_wr = 1'h0;
    rx_byte = ~rx_byte;
    frame_end = 1'h1;
    frame_ok = ok;
    @(posedge core_clk);
    #1;
    frame_end = 1'h0;
    frame_ok = ~ok;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the transmit buffers and receive filter
`timescale 1ns/1ps
`default_nettype none
module tb
  import cantxr_pkg::*;
;
  logic               core_clk, rst, sel_wr, win_wr, accept_wr, rx_release;
  logic               loopback, ts_enable, ovr_ie, rx_full_flag_ff, overrun_ff;
  logic               tx_req_ff, tx_extended_ff, ack_allow_ff;
  logic [N_TX-1:0]    sel_data, tx_release, tx_buffer_empty_flag_ff, tx_buffer_select_ff;
  logic [3:0]         win_addr, accept_addr, rx_rd_idx;
  logic [7:0]         win_wdata, accept_data, win_rdata_ff, rx_rdata_ff;
  logic [1:0]         filter_mode, tx_pick_ff;
  logic [HIT_W-1:0]   filter_hit_index_ff;
  logic [FRAME_W-1:0] tx_frame_ff, fm, fo;
  wire logic          tx_done, arb_lost, rx_byte_wr, frame_end, frame_ok;
  wire logic [15:0]   ts_value;
  wire logic [3:0]    rx_byte_idx;
  wire logic [7:0]    rx_byte;
  int                 num_errors, samples_checked, cycles;

  cantxr_top #(.DEPTH(4)) dut (.core_clk, .rst, .sel_wr, .sel_data, .win_wr, .win_addr, .win_wdata,
    .tx_release, .tx_buffer_empty_flag_ff, .tx_buffer_select_ff, .win_rdata_ff, .loopback, .ts_enable,
    .ovr_ie, .filter_mode, .accept_wr, .accept_addr, .accept_data, .rx_rd_idx, .rx_release, .rx_rdata_ff,
    .rx_full_flag_ff, .filter_hit_index_ff, .overrun_ff, .tx_req_ff, .tx_pick_ff, .tx_extended_ff,
    .tx_frame_ff, .ack_allow_ff, .tx_done, .arb_lost, .ts_value, .rx_byte_wr, .rx_byte_idx, .rx_byte,
    .frame_end, .frame_ok);
  cantxr_eng_model eng (.core_clk, .tx_req_ff, .tx_done, .arb_lost, .ts_value, .rx_byte_wr,
    .rx_byte_idx, .rx_byte, .frame_end, .frame_ok);

  // 10 MHz clock
  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // a hang ends the run; the scenarios need well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [FRAME_W-1:0] got, input logic [FRAME_W-1:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [FRAME_W-1:0] mkf(input logic [31:0] id, input logic [7:0] dlc);
    logic [FRAME_W-1:0] f;
    f = '0;
    for (int k = 0; k < 4; k++)
      f[8*k +: 8] = id[31-8*k -: 8];
    for (int k = 0; k < 8; k++)
      f[32+8*k +: 8] = 8'(8'hA0 + k);
    f[103:96] = dlc;
    return f;
  endfunction
  // data bytes past the length code go out as zero
  function automatic logic [FRAME_W-1:0] xf(input logic [FRAME_W-1:0] f);
    for (int k = 0; k < 8; k++)
      if (k >= f[99:96])
        f[32+8*k +: 8] = 8'h00;
    return f;
  endfunction
  task automatic sel(input logic [2:0] b);
    sel_wr = 1'h1;
    sel_data = b;
    step();
    sel_wr = 1'h0;
  endtask
  task automatic rel(input logic [2:0] b);
    tx_release = b;
    step();
    tx_release = 3'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    win_addr = a;
    step(2);
    chk(win_rdata_ff, exp);
  endtask
  // software picks an empty buffer, maps it and fills the window
  task automatic load(input logic [2:0] b, input logic [FRAME_W-1:0] f, input logic [7:0] p);
    chk(tx_buffer_empty_flag_ff & b, b);
    sel(b);
    for (int k = 0; k < 14; k++)
    begin
      win_wr = 1'h1;
      win_addr = k[3:0];
      win_wdata = (k == 13) ? p : f[8*k +: 8];
      step();
    end
    win_wr = 1'h0;
    chk(tx_buffer_select_ff, b);
  endtask
  task automatic wreq(input logic v);
    int n = 0;
    while (tx_req_ff !== v && n < 60)
    begin
      step();
      n++;
    end
    chk(tx_req_ff, v);
  endtask
  task automatic acc(input logic [3:0] a, input logic [7:0] d);
    accept_wr = 1'h1;
    accept_addr = a;
    accept_data = d;
    step();
    accept_wr = 1'h0;
    step();
  endtask
  // flags lag the fifo count by a cycle, so wait two
  task automatic pop();
    rx_release = 1'h1;
    step();
    rx_release = 1'h0;
    step(2);
  endtask
  task automatic head(input logic [7:0] exp);
    rx_rd_idx = 4'hC;
    step(2);
    chk(rx_rdata_ff, exp);
    pop();
  endtask
  task automatic rxc(input logic [FRAME_W-1:0] f, input logic ok, input logic st, input logic [2:0] hit);
    eng.send_rx(f, ok);
    step(2);
    chk(rx_full_flag_ff, st);
    if (st)
    begin
      chk(filter_hit_index_ff, hit);
      rx_rd_idx = 4'h1;
      step(2);
      chk(rx_rdata_ff, f[15:8]);
      pop();
    end
  endtask

  task automatic t_reset();
    chk(tx_buffer_empty_flag_ff, 3'h7);
    chk(tx_buffer_select_ff, 3'h0);
    chk(ack_allow_ff, 1'h1);
    chk(tx_req_ff, 1'h0);
  endtask
  // two ready buffers at once: the smaller priority value goes first
  task automatic t_tx();
    logic [FRAME_W-1:0] fa, fb;
    fa = mkf(32'h1230_0000, 8'h02);
    fb = mkf(32'hABCD_EF01, 8'h05);
    eng.busy = 6;
    load(3'h1, fa, 8'h05);
    rd(OFS_LOCAL_PRIORITY, 8'h05);
    load(3'h2, fb, 8'h02);
    rel(3'h3);
    wreq(1'h1);
    chk(tx_pick_ff, 2'h1);
    chk(tx_frame_ff, xf(fb));
    chk(tx_extended_ff, 1'h1);
    sel(3'h3);
    chk(tx_buffer_select_ff, 3'h0);
    wreq(1'h0);
    wreq(1'h1);
    chk(tx_pick_ff, 2'h0);
    chk(tx_frame_ff, xf(fa));
    chk(tx_extended_ff, 1'h0);
    wreq(1'h0);
    step(2);
    chk(tx_buffer_empty_flag_ff, 3'h7);
  endtask
  task automatic t_stamp();
    ts_enable = 1'h1;
    eng.ts_value = 16'hBEEF;
    load(3'h4, mkf(32'h0100_0000, 8'h08), 8'h00);
    rel(3'h4);
    wreq(1'h1);
    wreq(1'h0);
    step(2);
    sel(3'h4);
    rd(OFS_TS_HI, 8'hBE);
    rd(OFS_TS_LO, 8'hEF);
    ts_enable = 1'h0;
  endtask
  task automatic t_filt();
    rxc(fo, 1'h1, 1'h1, 3'h0);
    for (int k = 0; k < 4; k++)
    begin
      acc(k[3:0], 8'(8'hA1 + 8'h11 * k));
      acc(4'(8 + k), 8'h00);
    end
    rxc(fm, 1'h1, 1'h1, 3'h0);
    rxc(fo, 1'h1, 1'h1, 3'h1);
    for (int k = 0; k < 4; k++)
    begin
      acc(4'(4 + k), 8'(8'h11 * (k + 1)));
      acc(4'(12 + k), 8'h00);
    end
    rxc(mkf(32'h1122_3345, 8'h01), 1'h1, 1'h0, 3'h0);
    acc(4'hF, 8'h01);
    rxc(mkf(32'h1122_3345, 8'h01), 1'h1, 1'h1, 3'h1);
    rxc(fm, 1'h0, 1'h0, 3'h0);
    filter_mode = FMODE_FOUR;
    rxc(fo, 1'h1, 1'h1, 3'h2);
    filter_mode = FMODE_EIGHT;
    rxc(mkf(32'h4500_0000, 8'h01), 1'h1, 1'h1, 3'h7);
    filter_mode = FMODE_CLOSE;
    rxc(fm, 1'h1, 1'h0, 3'h0);
    filter_mode = FMODE_TWO;
  endtask
  // own frame while sending: dropped unless looped back or arbitration was lost
  task automatic t_own();
    eng.busy = 30;
    load(3'h1, fm, 8'h01);
    rel(3'h1);
    wreq(1'h1);
    step();
    chk(ack_allow_ff, 1'h0);
    rxc(fm, 1'h1, 1'h0, 3'h0);
    wreq(1'h0);
    loopback = 1'h1;
    load(3'h1, fm, 8'h01);
    rel(3'h1);
    wreq(1'h1);
    rxc(fm, 1'h1, 1'h1, 3'h0);
    wreq(1'h0);
    loopback = 1'h0;
    eng.busy = 8;
    eng.lose = 1'h1;
    load(3'h1, fm, 8'h01);
    rel(3'h1);
    rxc(fm, 1'h1, 1'h1, 3'h0);
    wreq(1'h0);
  endtask
  task automatic t_ovr();
    ovr_ie = 1'h1;
    for (int k = 1; k < 5; k++)
      eng.send_rx(mkf(32'hA1B2_C3D4, 8'(k)), 1'h1);
    eng.send_rx(fm, 1'h1);
    chk(overrun_ff, 1'h1);
    step();
    chk(overrun_ff, 1'h0);
    eng.busy = 3;
    load(3'h2, fo, 8'h00);
    rel(3'h2);
    wreq(1'h1);
    wreq(1'h0);
    head(8'h01);
    eng.send_rx(mkf(32'hA1B2_C3D4, 8'h07), 1'h1);
    step(2);
    head(8'h02);
    head(8'h03);
    head(8'h04);
    head(8'h07);
    chk(rx_full_flag_ff, 1'h0);
  endtask

  initial
  begin
    {rst, sel_wr, win_wr, accept_wr, rx_release, loopback, ts_enable, ovr_ie} = 8'h80;
    {sel_data, tx_release, win_addr, accept_addr, rx_rd_idx} = '0;
    {win_wdata, accept_data, filter_mode} = '0;
    fm = mkf(32'hA1B2_C3D4, 8'h01);
    fo = mkf(32'h1122_3344, 8'h01);
    step(12);
    rst = 1'h0;
    t_reset();
    t_tx();
    t_stamp();
    t_filt();
    t_own();
    t_ovr();
    end_of_test();
  end
endmodule
`default_nettype wire
